// >>> fwd_filter_params.svh
// offsets, field positions, reset values and figures of the filter control
`ifndef FWD_FILTER_PARAMS_SVH
`define FWD_FILTER_PARAMS_SVH
`define UVID_CTRL_ADDR      12'h328
`define MAC_CTRL0_ADDR      12'h330
`define MAC_CTRL1_ADDR      12'h334
`define UVID_EN_BIT         31
`define MAC0_ALT_BACKOFF    7
`define MAC0_LEN_CHECK      3
`define MAC0_FC_DROP_MODE   1
`define MAC0_AGGR_BACKOFF   0
`define MAC1_NO_XCOL_DROP   3
`define MAC0_RESET          8'h04
`define MAC1_RESET          8'h00
`define UVID_RESET          32'h0000_0000
`define LEN_TYPE_LIMIT      16'h05DC
`define PAUSE_ETHERTYPE     16'h8808
`define PAUSE_DA            48'h0180_C200_0001
`define XCOL_LIMIT          5'h10
`endif

// >>> fwd_filter_pkg.sv
// types shared by the filter control files
`default_nettype none
package fwd_filter_pkg;
  typedef logic [6:0] port_mask_t;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b11
  } bus_state_t;
endpackage
`default_nettype wire

// >>> frame_classifier.sv
// per-frame forwarding and drop decisions from the configuration
`timescale 1ns/1ps
`default_nettype none
`include "fwd_filter_params.svh"
module frame_classifier (
  input  wire logic                      uvid_en,
  input  wire fwd_filter_pkg::port_mask_t uvid_mask,
  input  wire logic                      len_check_en,
  input  wire logic                      fc_drop_any,
  input  wire logic                      vid_miss,
  input  wire logic                      da_unknown_uc,
  input  wire logic                      da_unknown_mc,
  input  wire fwd_filter_pkg::port_mask_t uc_fwd_mask,
  input  wire fwd_filter_pkg::port_mask_t mc_fwd_mask,
  input  wire logic [15:0]               len_type,
  input  wire logic [15:0]               meas_len,
  input  wire logic [47:0]               dest_addr,
  output logic                           special_fwd,
  output fwd_filter_pkg::port_mask_t     fwd_mask,
  output logic                           drop
);
  logic type_hit;
  logic da_hit;
  logic len_bad;
  logic fc_drop;

  always_comb begin
    special_fwd = 1'b0;
    fwd_mask    = '0;
    if (vid_miss) begin
      special_fwd = uvid_en;
      fwd_mask    = uvid_en ? uvid_mask : '0;
    end else if (da_unknown_uc) begin
      special_fwd = 1'b1;
      fwd_mask    = uc_fwd_mask;
    end else if (da_unknown_mc) begin
      special_fwd = 1'b1;
      fwd_mask    = mc_fwd_mask;
    end
  end

  assign type_hit = (len_type == `PAUSE_ETHERTYPE);
  assign da_hit   = (dest_addr == `PAUSE_DA);
  assign fc_drop  = fc_drop_any ? (type_hit | da_hit)
                                : (type_hit & da_hit);
  assign len_bad  = len_check_en && (len_type < `LEN_TYPE_LIMIT)
                    && (meas_len != len_type);
  assign drop     = fc_drop | len_bad;
endmodule // frame_classifier
`default_nettype wire

// >>> fwd_filter_ctrl.sv
// unknown-vid forwarding and mac policy register bank over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "fwd_filter_params.svh"
module fwd_filter_ctrl (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      hsel,
  input  wire logic [11:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      vid_miss,
  input  wire logic                      da_unknown_uc,
  input  wire logic                      da_unknown_mc,
  input  wire fwd_filter_pkg::port_mask_t uc_fwd_mask,
  input  wire fwd_filter_pkg::port_mask_t mc_fwd_mask,
  input  wire logic [15:0]               len_type,
  input  wire logic [15:0]               meas_len,
  input  wire logic [47:0]               dest_addr,
  output logic                           special_fwd,
  output fwd_filter_pkg::port_mask_t     fwd_mask,
  output logic                           frame_drop,
  input  wire fwd_filter_pkg::port_mask_t port_half_duplex,
  input  wire fwd_filter_pkg::port_mask_t collision,
  input  wire fwd_filter_pkg::port_mask_t tx_done,
  output fwd_filter_pkg::port_mask_t     alt_backoff_en,
  output fwd_filter_pkg::port_mask_t     aggr_backoff_en,
  output fwd_filter_pkg::port_mask_t     xcol_drop
);
  typedef struct packed {
    fwd_filter_pkg::bus_state_t bus;
    logic [11:0]                addr;
    logic [31:0]                rdata;
    logic                       uvid_en;
    fwd_filter_pkg::port_mask_t uvid_mask;
    logic [7:0]                 mac0;
    logic [7:0]                 mac1;
    logic [34:0]                col_cnt;
    fwd_filter_pkg::port_mask_t xcol;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   sel_ok;
  logic   [4:0] cnt_n;
  logic   [4:0] cnt_nxt;

  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input state_t s);
    read_word = 32'h0000_0000;
    if (a == `UVID_CTRL_ADDR)
      read_word = {s.uvid_en, 24'h00_0000, s.uvid_mask};
    else if (a == `MAC_CTRL0_ADDR)
      read_word = {24'h00_0000, s.mac0};
    else if (a == `MAC_CTRL1_ADDR)
      read_word = {24'h00_0000, s.mac1};
  endfunction

  assign sel_ok = hsel && hready && htrans[1];

  always_comb begin
    s_d = s_q;
    s_d.bus = fwd_filter_pkg::BUS_IDLE;
    if (s_q.bus == fwd_filter_pkg::BUS_WRITE) begin
      if (s_q.addr == `UVID_CTRL_ADDR) begin
        s_d.uvid_en   = hwdata[`UVID_EN_BIT];
        s_d.uvid_mask = hwdata[6:0];
      end else if (s_q.addr == `MAC_CTRL0_ADDR) begin
        s_d.mac0 = hwdata[7:0];
      end else if (s_q.addr == `MAC_CTRL1_ADDR) begin
        s_d.mac1 = hwdata[7:0];
      end
    end
    if (sel_ok) begin
      s_d.addr  = {haddr[11:2], 2'b00};
      s_d.bus   = hwrite ? fwd_filter_pkg::BUS_WRITE
                         : fwd_filter_pkg::BUS_READ;
      s_d.rdata = read_word({haddr[11:2], 2'b00}, s_q);
    end
    // per-port collision counters for excessive collision handling
    for (int p = 0; p < 7; p++) begin
      cnt_n   = s_q.col_cnt[p*5 +: 5];
      cnt_nxt = cnt_n;
      s_d.xcol[p] = 1'b0;
      if (tx_done[p]) begin
        cnt_nxt = 5'h00;
      end else if (collision[p] && port_half_duplex[p]) begin
        if (cnt_n + 5'h01 >= `XCOL_LIMIT) begin
          s_d.xcol[p] = !s_q.mac1[`MAC1_NO_XCOL_DROP];
          cnt_nxt = s_q.mac1[`MAC1_NO_XCOL_DROP]
                    ? `XCOL_LIMIT : 5'h00;
        end else begin
          cnt_nxt = cnt_n + 5'h01;
        end
      end
      s_d.col_cnt[p*5 +: 5] = cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q.bus       <= fwd_filter_pkg::BUS_IDLE;
      s_q.addr      <= 12'h000;
      s_q.rdata     <= 32'h0000_0000;
      s_q.uvid_en   <= 1'(`UVID_RESET >> `UVID_EN_BIT);
      s_q.uvid_mask <= 7'(`UVID_RESET);
      s_q.mac0      <= `MAC0_RESET;
      s_q.mac1      <= `MAC1_RESET;
      s_q.col_cnt   <= 35'h0_0000_0000;
      s_q.xcol      <= 7'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign xcol_drop = s_q.xcol;

  assign alt_backoff_en  = {7{s_q.mac0[`MAC0_ALT_BACKOFF]}}
                           & port_half_duplex;
  assign aggr_backoff_en = {7{s_q.mac0[`MAC0_AGGR_BACKOFF]}}
                           & port_half_duplex;

  frame_classifier u_cls (
    .uvid_en       (s_q.uvid_en),
    .uvid_mask     (s_q.uvid_mask),
    .len_check_en  (s_q.mac0[`MAC0_LEN_CHECK]),
    .fc_drop_any   (s_q.mac0[`MAC0_FC_DROP_MODE]),
    .vid_miss      (vid_miss),
    .da_unknown_uc (da_unknown_uc),
    .da_unknown_mc (da_unknown_mc),
    .uc_fwd_mask   (uc_fwd_mask),
    .mc_fwd_mask   (mc_fwd_mask),
    .len_type      (len_type),
    .meas_len      (meas_len),
    .dest_addr     (dest_addr),
    .special_fwd   (special_fwd),
    .fwd_mask      (fwd_mask),
    .drop          (frame_drop)
  );
endmodule // fwd_filter_ctrl
`default_nettype wire

// >>> fwd_filter_props.sv
// port assertions for the filter control bank
`timescale 1ns/1ps
`default_nettype none
module fwd_filter_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        vid_miss,
  input wire logic        da_unknown_uc,
  input wire logic        da_unknown_mc,
  input wire logic        special_fwd,
  input wire logic        frame_drop,
  input wire logic [15:0] len_type,
  input wire logic [15:0] meas_len,
  input wire logic [47:0] dest_addr,
  input wire logic [6:0]  fwd_mask,
  input wire logic [6:0]  port_half_duplex,
  input wire logic [6:0]  collision,
  input wire logic [6:0]  alt_backoff_en,
  input wire logic [6:0]  aggr_backoff_en,
  input wire logic [6:0]  xcol_drop
);
  localparam logic [47:0] pause_da = 48'h0180_C200_0001;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_alt; (alt_backoff_en & ~port_half_duplex) == 7'h00; endproperty
  a_alt: assert property (p_alt) else $error("alt full duplex");
  property p_agr; (aggr_backoff_en & ~port_half_duplex) == 7'h00; endproperty
  a_agr: assert property (p_agr) else $error("aggr full duplex");
  property p_known;
    !vid_miss && !da_unknown_uc && !da_unknown_mc |-> !special_fwd;
  endproperty
  a_known: assert property (p_known) else $error("fwd no cause");
  property p_prio; vid_miss && !special_fwd |-> fwd_mask == 7'h00; endproperty
  a_prio: assert property (p_prio) else $error("lower category");
  property p_both;
    len_type == 16'h8808 && dest_addr == pause_da |-> frame_drop;
  endproperty
  a_both: assert property (p_both) else $error("pause kept");
  property p_long;
    len_type >= 16'h05DC && len_type != 16'h8808 && dest_addr != pause_da
      |-> !frame_drop;
  endproperty
  a_long: assert property (p_long) else $error("typed dropped");
  property p_lenok;
    len_type < 16'h05DC && meas_len == len_type && dest_addr != pause_da
      |-> !frame_drop;
  endproperty
  a_lenok: assert property (p_lenok) else $error("len ok dropped");
  property p_xcol; (xcol_drop & ~$past(collision)) == 7'h00; endproperty
  a_xcol: assert property (p_xcol) else $error("xcol no cause");
  c_xcol: cover property (xcol_drop != 7'h00);
  c_drop: cover property (frame_drop);
  c_vid: cover property (vid_miss && special_fwd);
endmodule // fwd_filter_chk
bind fwd_filter_ctrl fwd_filter_chk u_fwd_filter_chk (.*);
`default_nettype wire

// >>> test_fwd_filter_ctrl.sv
// register and decision bench for the filter control bank
`timescale 1ns/1ps
`default_nettype none
module test_fwd_filter_ctrl;
  logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        vid_miss, da_unknown_uc, da_unknown_mc, special_fwd;
  logic        frame_drop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] len_type, meas_len;
  logic [47:0] dest_addr;
  logic [6:0]  uc_fwd_mask, mc_fwd_mask, fwd_mask, port_half_duplex;
  logic [6:0]  collision, tx_done, alt_backoff_en, aggr_backoff_en, xcol_drop;
  int          failures, total_checks;
  assign hready = hreadyout;
  fwd_filter_ctrl u_fwd_filter_ctrl (.*);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic edge_rdy();
    repeat (20) begin
      @(posedge ref_clk);
      if (hready === 1'b1) return;
    end
    failures++;
    stop_test();
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, [31:0] d);
    @(posedge ref_clk);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic frame(input logic [1:0] vu, input logic [15:0] lt, ml,
                       input logic [47:0] da);
    @(posedge ref_clk);
    {vid_miss, da_unknown_uc} <= vu;
    len_type  <= lt;
    meas_len  <= ml;
    dest_addr <= da;
    @(negedge ref_clk);
  endtask
  task automatic collide(input int n, input logic [31:0] e);
    repeat (n) begin
      @(posedge ref_clk);
      collision <= 7'h01;
      @(posedge ref_clk);
      collision <= 7'h00;
      @(negedge ref_clk);
      chk("xcol", xcol_drop, e);
    end
  endtask
  initial begin
    {hwrite, htrans, haddr, hwdata, vid_miss, da_unknown_uc} = '0;
    {da_unknown_mc, len_type, meas_len, dest_addr, collision} = '0;
    {uc_fwd_mask, mc_fwd_mask, tx_done, port_half_duplex} = '0;
    {uc_fwd_mask, mc_fwd_mask} = {7'h11, 7'h22};
    {rst, hsel, hsize} = 5'h1A;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(1'b0, 12'h328, 32'h0);
    chk("uvid reset", rd, 32'h0);
    xfer(1'b0, 12'h330, 32'h0);
    chk("mac0 reset", rd, 32'h04);
    xfer(1'b0, 12'h334, 32'h0);
    chk("mac1 reset", rd, 32'h0);
    xfer(1'b0, 12'h33C, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("resp", {hreadyout, hresp}, 32'h2);
    xfer(1'b1, 12'h328, 32'hFFFF_FFFF);
    xfer(1'b0, 12'h328, 32'h0);
    chk("uvid rd", rd, 32'h8000_007F);
    frame(2'b11, 16'h0800, 16'h0040, 48'h0);
    chk("all ports", {special_fwd, fwd_mask}, 32'hFF);
    xfer(1'b1, 12'h328, 32'h8000_0002);
    frame(2'b10, 16'h0800, 16'h0040, 48'h0);
    chk("port two", fwd_mask, 32'h02);
    xfer(1'b1, 12'h328, 32'h8000_0000);
    frame(2'b10, 16'h0800, 16'h0040, 48'h0);
    chk("no port", {special_fwd, fwd_mask}, 32'h80);
    xfer(1'b1, 12'h328, 32'h0000_0055);
    frame(2'b11, 16'h0800, 16'h0040, 48'h0);
    chk("disabled", {special_fwd, fwd_mask}, 32'h0);
    frame(2'b01, 16'h0800, 16'h0040, 48'h0);
    chk("unknown uc", {special_fwd, fwd_mask}, 32'h91);
    @(posedge ref_clk) da_unknown_mc <= 1'b1;
    frame(2'b01, 16'h0800, 16'h0040, 48'h0);
    chk("uc over mc", {special_fwd, fwd_mask}, 32'h91);
    frame(2'b00, 16'h0800, 16'h0040, 48'h0);
    chk("unknown mc", {special_fwd, fwd_mask}, 32'hA2);
    frame(2'b10, 16'h0800, 16'h0040, 48'h0);
    chk("vid over mc", {special_fwd, fwd_mask}, 32'h0);
    @(posedge ref_clk) da_unknown_mc <= 1'b0;
    $display("test unknown vid done");
    @(posedge ref_clk) port_half_duplex <= 7'h0F;
    xfer(1'b1, 12'h330, 32'h89);
    frame(2'b00, 16'h0064, 16'h0063, 48'h0);
    chk("alt", alt_backoff_en, 32'h0F);
    chk("aggr", aggr_backoff_en, 32'h0F);
    chk("len bad", frame_drop, 32'h1);
    frame(2'b00, 16'h05DC, 16'h0063, 48'h0);
    chk("typed", frame_drop, 32'h0);
    frame(2'b00, 16'h8808, 16'h0040, 48'h0);
    chk("type only", frame_drop, 32'h0);
    frame(2'b00, 16'h8808, 16'h0040, 48'h0180_C200_0001);
    chk("both", frame_drop, 32'h1);
    xfer(1'b1, 12'h330, 32'h02);
    frame(2'b00, 16'h0800, 16'h0040, 48'h0180_C200_0001);
    chk("da only", frame_drop, 32'h1);
    frame(2'b00, 16'h8808, 16'h0040, 48'h0);
    chk("type any", frame_drop, 32'h1);
    chk("alt off", alt_backoff_en, 32'h0);
    frame(2'b00, 16'h0064, 16'h0063, 48'h0);
    chk("no len chk", frame_drop, 32'h0);
    $display("test mac policy done");
    collide(15, 32'h0);
    collide(1, 32'h1);
    xfer(1'b1, 12'h330, 32'h80);
    xfer(1'b1, 12'h334, 32'h08);
    xfer(1'b0, 12'h334, 32'h0);
    chk("mac1 rd", rd, 32'h08);
    collide(17, 32'h0);
    @(posedge ref_clk) tx_done <= 7'h01;
    @(posedge ref_clk) tx_done <= 7'h00;
    xfer(1'b1, 12'h334, 32'h00);
    collide(15, 32'h0);
    collide(1, 32'h1);
    $display("test collision done");
    stop_test();
  end
endmodule // test_fwd_filter_ctrl
`default_nettype wire
